// [design/stop_reaction.sv]
// What this block does
// - Quick-stop ramp is speed step over time step; resets 0x1388 and 0x0001
// - Internal speed to rev/s uses first factor multiply, second divide
// - Both unit factors equal one means speeds are in rev/min
// - Unit factors reset to 1 and 60, meaning rev/min
// - Quick stop entry: 0 immediate, 1 slow ramp, 2 quick ramp; only 1 and 2 then go switch on disabled
// - Quick ramp braking uses quick-stop fraction in velocity mode only; switch on disabled follows only on quick stop
// - Slow ramp braking uses active mode deceleration; switch on disabled follows only on quick stop
// - Operation enabled to ready: shutdown option 0 immediate, 1 slow ramp
// - Operation enabled to switched on: disable option 0 immediate, 1 slow ramp
// - Controlword bit 8 requests halt, acting per halt option
// - Halt option 1 slow ramp, 2 quick ramp, resets to 1
`timescale 1ns/100ps
module stop_reaction (
    input  wire logic                          clk_sys,
    input  wire logic                          arst_n,
    input  wire logic                          obj_wr,
    input  wire logic                          obj_rd,
    input  wire logic [15:0]                   obj_index,
    input  wire logic [7:0]                    obj_sub,
    input  wire logic [31:0]                   obj_wdata,
    input  wire logic [15:0]                   controlword,
    input  wire stop_reaction_pkg::power_state_type ps_from,
    input  wire stop_reaction_pkg::power_state_type ps_to,
    input  wire logic                          ps_change,
    input  wire logic                          velocity_mode,
    input  wire logic                          brake_done,
    output logic [31:0]                        obj_rdata,
    output logic                               obj_ack,
    output logic                               obj_err,
    output stop_reaction_pkg::brake_type       brake_cmd,
    output logic                               use_quick_ramp,
    output logic [31:0]                        ramp_speed_step,
    output logic [15:0]                        ramp_time_step,
    output logic [31:0]                        unit_mul,
    output logic [31:0]                        unit_div,
    output logic                               unit_is_rpm,
    output logic                               go_switch_on_disabled
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [15:0]                 qs_react;
        logic [15:0]                 sd_react;
        logic [15:0]                 dis_react;
        logic [15:0]                 halt_react;
        logic [31:0]                 speed_step;
        logic [15:0]                 time_step;
        logic [31:0]                 mul;
        logic [31:0]                 div;
        logic [31:0]                 rdata;
        logic                        ack;
        logic                        err;
        stop_reaction_pkg::brake_type brake;
        logic                        quick;
        logic                        to_disabled;
        logic                        done_pulse;
        logic                        halt_prev;
        logic                        rpm;
    } state_type;

    state_type s_q;
    state_type s_d;

    function automatic stop_reaction_pkg::brake_type decode_option(input logic [15:0] opt);
        case (opt)
            stop_reaction_pkg::OPT_IMMEDIATE:  decode_option = stop_reaction_pkg::BRAKE_IMMED;
            stop_reaction_pkg::OPT_SLOW_RAMP:  decode_option = stop_reaction_pkg::BRAKE_SLOW;
            stop_reaction_pkg::OPT_QUICK_RAMP: decode_option = stop_reaction_pkg::BRAKE_QUICK;
            default:                           decode_option = stop_reaction_pkg::BRAKE_NONE;
        endcase
    endfunction

    logic halt_req;
    assign halt_req = controlword[stop_reaction_pkg::CW_HALT_BIT];

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [15:0] w16;
        w16 = obj_wdata[15:0];
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        s_d.done_pulse = 1'b0;
        s_d.halt_prev = halt_req;
        if (obj_wr) begin
            s_d.ack = 1'b1;
            s_d.err = 1'b1;
            case (obj_index)
                stop_reaction_pkg::IDX_QS_REACT: begin
                    if (w16 == stop_reaction_pkg::OPT_IMMEDIATE || w16 == stop_reaction_pkg::OPT_SLOW_RAMP ||
                        w16 == stop_reaction_pkg::OPT_QUICK_RAMP) begin
                        s_d.qs_react = w16;
                        s_d.err = 1'b0;
                    end
                end
                stop_reaction_pkg::IDX_SD_REACT: begin
                    if (w16 == stop_reaction_pkg::OPT_IMMEDIATE || w16 == stop_reaction_pkg::OPT_SLOW_RAMP) begin
                        s_d.sd_react = w16;
                        s_d.err = 1'b0;
                    end
                end
                stop_reaction_pkg::IDX_DIS_REACT: begin
                    if (w16 == stop_reaction_pkg::OPT_IMMEDIATE || w16 == stop_reaction_pkg::OPT_SLOW_RAMP) begin
                        s_d.dis_react = w16;
                        s_d.err = 1'b0;
                    end
                end
                stop_reaction_pkg::IDX_HALT_REACT: begin
                    if (w16 == stop_reaction_pkg::OPT_SLOW_RAMP || w16 == stop_reaction_pkg::OPT_QUICK_RAMP) begin
                        s_d.halt_react = w16;
                        s_d.err = 1'b0;
                    end
                end
                stop_reaction_pkg::IDX_QS_RAMP: begin
                    if (obj_sub == stop_reaction_pkg::SUB_FIRST) begin
                        s_d.speed_step = obj_wdata;
                        s_d.err = 1'b0;
                    end else if (obj_sub == stop_reaction_pkg::SUB_SECOND && w16 != 16'h0000) begin
                        s_d.time_step = w16;
                        s_d.err = 1'b0;
                    end
                end
                stop_reaction_pkg::IDX_VEL_UNIT: begin
                    if (obj_sub == stop_reaction_pkg::SUB_FIRST && obj_wdata != 32'h00000000) begin
                        s_d.mul = obj_wdata;
                        s_d.err = 1'b0;
                    end else if (obj_sub == stop_reaction_pkg::SUB_SECOND && obj_wdata != 32'h00000000) begin
                        s_d.div = obj_wdata;
                        s_d.err = 1'b0;
                    end
                end
                default: s_d.err = 1'b1;
            endcase
        end else if (obj_rd) begin
            s_d.ack = 1'b1;
            s_d.rdata = 32'h00000000;
            case (obj_index)
                stop_reaction_pkg::IDX_QS_REACT:   s_d.rdata = {16'h0000, s_q.qs_react};
                stop_reaction_pkg::IDX_SD_REACT:   s_d.rdata = {16'h0000, s_q.sd_react};
                stop_reaction_pkg::IDX_DIS_REACT:  s_d.rdata = {16'h0000, s_q.dis_react};
                stop_reaction_pkg::IDX_HALT_REACT: s_d.rdata = {16'h0000, s_q.halt_react};
                stop_reaction_pkg::IDX_QS_RAMP: begin
                    case (obj_sub)
                        stop_reaction_pkg::SUB_COUNT:  s_d.rdata = {24'h000000, stop_reaction_pkg::ENTRIES_RST};
                        stop_reaction_pkg::SUB_FIRST:  s_d.rdata = s_q.speed_step;
                        stop_reaction_pkg::SUB_SECOND: s_d.rdata = {16'h0000, s_q.time_step};
                        default:                       s_d.err = 1'b1;
                    endcase
                end
                stop_reaction_pkg::IDX_VEL_UNIT: begin
                    case (obj_sub)
                        stop_reaction_pkg::SUB_COUNT:  s_d.rdata = {24'h000000, stop_reaction_pkg::ENTRIES_RST};
                        stop_reaction_pkg::SUB_FIRST:  s_d.rdata = s_q.mul;
                        stop_reaction_pkg::SUB_SECOND: s_d.rdata = s_q.div;
                        default:                       s_d.err = 1'b1;
                    endcase
                end
                default: s_d.err = 1'b1;
            endcase
        end
        // Stop reaction selection
        if (ps_change && ps_to == stop_reaction_pkg::PS_QUICK_STOP_ACTIVE) begin
            s_d.brake = decode_option(s_q.qs_react);
            s_d.to_disabled = (s_q.qs_react != stop_reaction_pkg::OPT_IMMEDIATE);
        end else if (ps_change && ps_from == stop_reaction_pkg::PS_OPERATION_ENABLED &&
                     ps_to == stop_reaction_pkg::PS_READY_TO_SWITCH_ON) begin
            s_d.brake = decode_option(s_q.sd_react);
            s_d.to_disabled = 1'b0;
        end else if (ps_change && ps_from == stop_reaction_pkg::PS_OPERATION_ENABLED &&
                     ps_to == stop_reaction_pkg::PS_SWITCHED_ON) begin
            s_d.brake = decode_option(s_q.dis_react);
            s_d.to_disabled = 1'b0;
        end else if (halt_req && !s_q.halt_prev) begin
            s_d.brake = decode_option(s_q.halt_react);
            s_d.to_disabled = 1'b0;
        end else if (!halt_req && s_q.halt_prev && !s_q.to_disabled) begin
            s_d.brake = stop_reaction_pkg::BRAKE_NONE;
        end else if (brake_done && s_q.brake != stop_reaction_pkg::BRAKE_NONE) begin
            s_d.done_pulse = s_q.to_disabled;
            s_d.to_disabled = 1'b0;
            s_d.brake = stop_reaction_pkg::BRAKE_NONE;
        end
        s_d.quick = (s_d.brake == stop_reaction_pkg::BRAKE_QUICK) && velocity_mode;
        s_d.rpm = (s_d.mul == 32'h00000001 && s_d.div == 32'h00000001) ||
                  (s_d.mul == 32'h00000001 && s_d.div == 32'h0000003C);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{qs_react:   stop_reaction_pkg::REACT_RST,
                     sd_react:   stop_reaction_pkg::REACT_RST,
                     dis_react:  stop_reaction_pkg::REACT_RST,
                     halt_react: stop_reaction_pkg::REACT_RST,
                     speed_step: stop_reaction_pkg::SPEED_STEP_RST,
                     time_step:  stop_reaction_pkg::TIME_STEP_RST,
                     mul:        stop_reaction_pkg::UNIT_MUL_RST,
                     div:        stop_reaction_pkg::UNIT_DIV_RST,
                     rdata:      32'h00000000,
                     ack:        1'b0,
                     err:        1'b0,
                     brake:      stop_reaction_pkg::BRAKE_NONE,
                     quick:      1'b0,
                     to_disabled: 1'b0,
                     done_pulse: 1'b0,
                     halt_prev:  1'b0,
                     rpm:        1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign obj_rdata             = s_q.rdata;
    assign obj_ack               = s_q.ack;
    assign obj_err               = s_q.err;
    assign brake_cmd             = s_q.brake;
    assign use_quick_ramp        = s_q.quick;
    assign ramp_speed_step       = s_q.speed_step;
    assign ramp_time_step        = s_q.time_step;
    assign unit_mul              = s_q.mul;
    assign unit_div              = s_q.div;
    assign unit_is_rpm           = s_q.rpm;
    assign go_switch_on_disabled = s_q.done_pulse;
endmodule // stop_reaction

// [include/stop_reaction_pkg.sv]
package stop_reaction_pkg;
    // ****************************************
    // Object indices and sub-indices
    // ****************************************
    localparam logic [15:0] IDX_QS_RAMP      = 16'h604A;
    localparam logic [15:0] IDX_VEL_UNIT     = 16'h604C;
    localparam logic [15:0] IDX_QS_REACT     = 16'h605A;
    localparam logic [15:0] IDX_SD_REACT     = 16'h605B;
    localparam logic [15:0] IDX_DIS_REACT    = 16'h605C;
    localparam logic [15:0] IDX_HALT_REACT   = 16'h605D;
    localparam logic [7:0]  SUB_COUNT        = 8'h00;
    localparam logic [7:0]  SUB_FIRST        = 8'h01;
    localparam logic [7:0]  SUB_SECOND       = 8'h02;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0]  ENTRIES_RST      = 8'h02;
    localparam logic [31:0] SPEED_STEP_RST   = 32'h00001388;
    localparam logic [15:0] TIME_STEP_RST    = 16'h0001;
    localparam logic [31:0] UNIT_MUL_RST     = 32'h00000001;
    localparam logic [31:0] UNIT_DIV_RST     = 32'h0000003C;
    localparam logic [15:0] REACT_RST        = 16'h0001;
    // ****************************************
    // Option codes and controlword
    // ****************************************
    localparam logic [15:0] OPT_IMMEDIATE    = 16'h0000;
    localparam logic [15:0] OPT_SLOW_RAMP    = 16'h0001;
    localparam logic [15:0] OPT_QUICK_RAMP   = 16'h0002;
    localparam int          CW_HALT_BIT      = 8;
    // ****************************************
    // Power states and braking actions
    // ****************************************
    typedef enum logic [2:0] {
        PS_SWITCH_ON_DISABLED = 3'b000,
        PS_READY_TO_SWITCH_ON = 3'b001,
        PS_SWITCHED_ON        = 3'b010,
        PS_OPERATION_ENABLED  = 3'b011,
        PS_QUICK_STOP_ACTIVE  = 3'b100
    } power_state_type;
    typedef enum logic [1:0] {
        BRAKE_NONE  = 2'b00,
        BRAKE_IMMED = 2'b01,
        BRAKE_SLOW  = 2'b10,
        BRAKE_QUICK = 2'b11
    } brake_type;
endpackage

// [tb/brake_load_model.sv]
`timescale 1ns/100ps
// ****************************************
// Drive side finishing each stop
// ****************************************
module brake_load_model (
    input  wire logic                         clk_sys,
    input  wire logic                         arst_n,
    input  wire logic                         slow,
    input  wire stop_reaction_pkg::brake_type brake_cmd,
    output logic                              brake_done
);
    logic [3:0] wait_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wait_q <= 4'h0;
            brake_done <= 1'b0;
        end else begin
            brake_done <= 1'b0;
            if (brake_cmd == stop_reaction_pkg::BRAKE_NONE) begin
                wait_q <= 4'h0;
            end else if (wait_q == (slow ? 4'h6 : 4'h2)) begin
                brake_done <= 1'b1;
                wait_q <= 4'hF;
            end else if (wait_q != 4'hF) begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule // brake_load_model

// [tb/stop_reaction_chk.sv]
`timescale 1ns/100ps
// ****************************************
// Port checks
// ****************************************
module stop_reaction_chk (
    input wire logic                                clk_sys,
    input wire logic                                arst_n,
    input wire logic                                obj_wr,
    input wire logic                                obj_rd,
    input wire logic [15:0]                         controlword,
    input wire stop_reaction_pkg::power_state_type  ps_from,
    input wire stop_reaction_pkg::power_state_type  ps_to,
    input wire logic                                ps_change,
    input wire logic                                brake_done,
    input wire logic                                obj_ack,
    input wire logic                                obj_err,
    input wire stop_reaction_pkg::brake_type        brake_cmd,
    input wire logic                                use_quick_ramp,
    input wire logic [15:0]                         ramp_time_step,
    input wire logic [31:0]                         unit_mul,
    input wire logic [31:0]                         unit_div,
    input wire logic                                unit_is_rpm,
    input wire logic                                go_switch_on_disabled
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    property p_ack; obj_ack == $past(obj_wr || obj_rd); endproperty
    property p_err; obj_err |-> obj_ack; endproperty
    property p_quick; ps_change && ps_to == stop_reaction_pkg::PS_QUICK_STOP_ACTIVE
        |=> brake_cmd != stop_reaction_pkg::BRAKE_NONE; endproperty
    property p_shut; ps_change && ps_from == stop_reaction_pkg::PS_OPERATION_ENABLED &&
        ps_to == stop_reaction_pkg::PS_READY_TO_SWITCH_ON
        |=> brake_cmd inside {stop_reaction_pkg::BRAKE_IMMED, stop_reaction_pkg::BRAKE_SLOW}; endproperty
    property p_dis; ps_change && ps_from == stop_reaction_pkg::PS_OPERATION_ENABLED &&
        ps_to == stop_reaction_pkg::PS_SWITCHED_ON
        |=> brake_cmd inside {stop_reaction_pkg::BRAKE_IMMED, stop_reaction_pkg::BRAKE_SLOW}; endproperty
    property p_qramp; use_quick_ramp |-> brake_cmd == stop_reaction_pkg::BRAKE_QUICK; endproperty
    property p_go; go_switch_on_disabled |-> $past(brake_done); endproperty
    property p_rpm; unit_is_rpm == (unit_mul == 32'h1 && (unit_div == 32'h1 || unit_div == 32'h3C)); endproperty
    property p_nz; unit_div != 32'h0 && ramp_time_step != 16'h0; endproperty
    property p_halt; $rose(controlword[8]) && !ps_change && brake_cmd == stop_reaction_pkg::BRAKE_NONE
        |=> brake_cmd inside {stop_reaction_pkg::BRAKE_SLOW, stop_reaction_pkg::BRAKE_QUICK}; endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    a_err: assert property (p_err) else $error("err without ack");
    a_quick: assert property (p_quick) else $error("no braking on quick stop");
    a_shut: assert property (p_shut) else $error("bad shutdown braking");
    a_dis: assert property (p_dis) else $error("bad disable braking");
    a_qramp: assert property (p_qramp) else $error("quick ramp without quick braking");
    a_go: assert property (p_go) else $error("switch on disabled before braking done");
    a_rpm: assert property (p_rpm) else $error("rpm flag wrong");
    a_nz: assert property (p_nz) else $error("zero divisor held");
    a_halt: assert property (p_halt) else $error("no braking on halt");
    c_quick: cover property (p_quick);
    c_go: cover property (go_switch_on_disabled);
    c_err: cover property (obj_err);
endmodule // stop_reaction_chk
bind stop_reaction stop_reaction_chk chk_u (.clk_sys, .arst_n, .obj_wr, .obj_rd, .controlword, .ps_from, .ps_to,
    .ps_change, .brake_done, .obj_ack, .obj_err, .brake_cmd, .use_quick_ramp, .ramp_time_step, .unit_mul,
    .unit_div, .unit_is_rpm, .go_switch_on_disabled);

// [tb/tb.sv]
`timescale 1ns/100ps
// ****************************************
// Object access and stop reactions
// ****************************************
module tb;
    logic clk_sys, arst_n, obj_wr, obj_rd, ps_change, velocity_mode, brake_done, slow, seen, er;
    logic obj_ack, obj_err, use_quick_ramp, unit_is_rpm, go_switch_on_disabled;
    logic [15:0] obj_index, controlword, ramp_time_step;
    logic [7:0]  obj_sub;
    logic [31:0] obj_wdata, obj_rdata, unit_mul, unit_div, ramp_speed_step, rd;
    stop_reaction_pkg::power_state_type ps_from, ps_to;
    stop_reaction_pkg::brake_type       brake_cmd;
    int          failures, comparisons;
    localparam logic [55:0] RST [10] = '{56'h604A0000000002, 56'h604A0100001388, 56'h604A0200000001,
        56'h604C0000000002, 56'h604C0100000001, 56'h604C020000003C, 56'h605A0000000001,
        56'h605B0000000001, 56'h605C0000000001, 56'h605D0000000001};
    localparam logic [47:0] BAD [6] = '{48'h605A00000003, 48'h605A0000FFFF, 48'h605B00000002,
        48'h605C00000002, 48'h605D00000000, 48'h605D00000003};
    stop_reaction dut_u (.clk_sys, .arst_n, .obj_wr, .obj_rd, .obj_index, .obj_sub, .obj_wdata, .controlword,
        .ps_from, .ps_to, .ps_change, .velocity_mode, .brake_done, .obj_rdata, .obj_ack, .obj_err, .brake_cmd,
        .use_quick_ramp, .ramp_speed_step, .ramp_time_step, .unit_mul, .unit_div, .unit_is_rpm,
        .go_switch_on_disabled);
    brake_load_model load_u (.clk_sys, .arst_n, .slow, .brake_cmd, .brake_done);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
        obj_wr = wr;
        obj_rd = !wr;
        obj_index = idx;
        obj_sub = sub;
        obj_wdata = d;
        @(negedge clk_sys);
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        for (int i = 0; i < 3 && obj_ack !== 1'b1; i++) @(negedge clk_sys);
        chk("ack", 32'h1, {31'h0, obj_ack});
        rd = obj_rdata;
        er = obj_err;
        @(negedge clk_sys);
    endtask
    task automatic wrx(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic e);
        acc(1'b1, idx, sub, d);
        chk("write refused", {31'h0, e}, {31'h0, er});
    endtask
    task automatic rdx(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
        acc(1'b0, idx, sub, 32'h0);
        chk("read data", e, rd);
    endtask
    task automatic trans(input stop_reaction_pkg::power_state_type t, input logic [1:0] exp, input logic go);
        ps_from = stop_reaction_pkg::PS_OPERATION_ENABLED;
        ps_to = t;
        ps_change = 1'b1;
        @(negedge clk_sys);
        ps_change = 1'b0;
        seen = 1'b0;
        chk("brake command", {30'h0, exp}, {30'h0, brake_cmd});
        chk("quick ramp flag", {31'h0, exp == 2'h3 && velocity_mode}, {31'h0, use_quick_ramp});
        for (int i = 0; i < 12 && brake_cmd !== stop_reaction_pkg::BRAKE_NONE; i++) begin
            @(negedge clk_sys);
            seen = seen | go_switch_on_disabled;
        end
        chk("to switch on disabled", {31'h0, go}, {31'h0, seen});
        @(negedge clk_sys);
    endtask
    task automatic end_sim;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        end_sim;
    end
    initial begin
        {obj_wr, obj_rd, ps_change, slow, arst_n} = 5'h0;
        {obj_index, obj_sub, obj_wdata, controlword} = 72'h0;
        velocity_mode = 1'b1;
        ps_from = stop_reaction_pkg::PS_SWITCH_ON_DISABLED;
        ps_to = stop_reaction_pkg::PS_SWITCH_ON_DISABLED;
        repeat (20) @(negedge clk_sys);
        arst_n = 1'b1;
        @(negedge clk_sys);
        chk("speed step port", 32'h1388, ramp_speed_step);
        chk("unit divisor port", 32'h3C, unit_div);
        for (int i = 0; i < 10; i++) rdx(RST[i][55:40], RST[i][39:32], RST[i][31:0]);
        wrx(16'h6060, 8'h00, 32'h1, 1'b1);
        wrx(16'h604A, 8'h00, 32'h3, 1'b1);
        for (int i = 0; i < 6; i++) begin
            wrx(BAD[i][47:32], 8'h00, BAD[i][31:0], 1'b1);
            rdx(BAD[i][47:32], 8'h00, 32'h1);
        end
        wrx(16'h604C, 8'h02, 32'h0, 1'b1);
        wrx(16'h604C, 8'h01, 32'h0, 1'b1);
        wrx(16'h604A, 8'h02, 32'h0, 1'b1);
        chk("time step kept", 32'h1, {16'h0, ramp_time_step});
        wrx(16'h604C, 8'h01, 32'h7, 1'b0);
        wrx(16'h604C, 8'h02, 32'h3, 1'b0);
        chk("factors", 32'h73, {unit_mul[3:0], unit_div[3:0]});
        chk("rpm off", 32'h0, {31'h0, unit_is_rpm});
        wrx(16'h604C, 8'h01, 32'h1, 1'b0);
        wrx(16'h604C, 8'h02, 32'h1, 1'b0);
        chk("rpm on", 32'h1, {31'h0, unit_is_rpm});
        wrx(16'h604A, 8'h01, 32'h2710, 1'b0);
        chk("speed step", 32'h2710, ramp_speed_step);
        for (int v = 0; v < 3; v++) begin
            slow = v[0];
            wrx(16'h605A, 8'h00, v, 1'b0);
            trans(stop_reaction_pkg::PS_QUICK_STOP_ACTIVE, 2'(v + 1), v != 0);
        end
        for (int v = 0; v < 2; v++) begin
            wrx(16'h605B, 8'h00, v, 1'b0);
            wrx(16'h605C, 8'h00, v, 1'b0);
            trans(stop_reaction_pkg::PS_READY_TO_SWITCH_ON, 2'(v + 1), 1'b0);
            trans(stop_reaction_pkg::PS_SWITCHED_ON, 2'(v + 1), 1'b0);
        end
        for (int v = 1; v < 3; v++) begin
            wrx(16'h605D, 8'h00, v, 1'b0);
            controlword[8] = 1'b1;
            @(negedge clk_sys);
            chk("halt brake", 32'(v + 1), {30'h0, brake_cmd});
            controlword[8] = 1'b0;
            for (int i = 0; i < 8 && brake_cmd !== stop_reaction_pkg::BRAKE_NONE; i++) @(negedge clk_sys);
        end
        velocity_mode = 1'b0;
        trans(stop_reaction_pkg::PS_QUICK_STOP_ACTIVE, 2'h3, 1'b1);
        end_sim;
    end
endmodule // tb
